// >>> dv/nvm_programmer.sv
`timescale 1ns/100ps
`default_nettype none
module nvm_programmer
	import nvm_port_pkg::*;
(
	// Clock
	input  wire logic       i_ref_clk,
	// Read side of the bus
	input  wire logic [7:0] i_rd_data,
	// Strobes, selects and bus
	output logic            o_load_strobe,
	output logic            o_page_latch,
	output logic            o_wr_n,
	output logic            o_oe_n,
	output var ctl_s        o_ctl,
	output logic      [7:0] o_data
);
	initial begin
		o_load_strobe = 1'b0;
		o_page_latch = 1'b0;
		o_wr_n = 1'b1;
		o_oe_n = 1'b1;
		o_ctl = 4'hC;
		o_data = 8'h00;
	end

	// Levels set a cycle ahead; control held past the strobe, data inverted as it falls
	task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] val);
		@(negedge i_ref_clk);
		o_ctl = {act, bs1, 1'b0};
		o_data = val;
		@(negedge i_ref_clk);
		o_load_strobe = 1'b1;
		@(negedge i_ref_clk);
		o_load_strobe = 1'b0;
		o_data = ~val;
	endtask : load

	task automatic latch(input logic bs1);
		@(negedge i_ref_clk);
		o_ctl = {ACT_IDLE, bs1, 1'b0};
		@(negedge i_ref_clk);
		o_page_latch = 1'b1;
		@(negedge i_ref_clk);
		o_page_latch = 1'b0;
	endtask : latch

	task automatic wr(input logic bs1, input logic bs2);
		@(negedge i_ref_clk);
		o_ctl = {ACT_IDLE, bs1, bs2};
		@(negedge i_ref_clk);
		o_wr_n = 1'b0;
		@(negedge i_ref_clk);
		o_wr_n = 1'b1;
	endtask : wr

	// Bus driven with inverted data by the programmer while reading
	task automatic rd(input logic bs1, input logic bs2, output logic [7:0] val);
		@(negedge i_ref_clk);
		o_ctl = {ACT_IDLE, bs1, bs2};
		o_oe_n = 1'b0;
		o_data = ~o_data;
		@(negedge i_ref_clk);
		@(negedge i_ref_clk);
		val = i_rd_data;
		o_oe_n = 1'b1;
	endtask : rd
endmodule : nvm_programmer
`default_nettype wire

// >>> dv/parallel_nvm_programming_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
module parallel_nvm_programming_port_bench;
	import nvm_port_pkg::*;
	logic       i_ref_clk;
	logic       i_rst_n;
	logic       load_strobe;
	logic       page_latch;
	logic       wr_n;
	logic       oe_n;
	ctl_s       ctl;
	logic [7:0] bus_out;
	logic [7:0] rd_data;
	logic       data_oe_n;
	logic       ready;
	logic [7:0] v;
	int         bad_count;
	int         n_tests;
	int         cycles;

	nvm_programmer pgm (.i_ref_clk(i_ref_clk), .i_rd_data(rd_data), .o_load_strobe(load_strobe),
		.o_page_latch(page_latch), .o_wr_n(wr_n), .o_oe_n(oe_n), .o_ctl(ctl), .o_data(bus_out));

	nvm_prog_port #(.PROG_CYCLES_P(40)) DUT (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_load_strobe(load_strobe), .i_page_buffer_latch(page_latch), .i_wr_n(wr_n),
		.i_oe_n(oe_n), .i_ctl(ctl), .i_data(bus_out), .o_data(rd_data),
		.o_data_oe_n(data_oe_n), .o_ready_busy_out(ready));

	initial i_ref_clk = 1'b0;
	always #50 i_ref_clk = ~i_ref_clk;

	task automatic test_done;
		$display("Counts: %0d compares, %0d mismatches", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done

	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			test_done();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Busy right after the pulse, then ready within a bound
	task automatic wait_ready;
		int n;
		chk({7'h00, ready}, 8'h00);
		n = 0;
		while (ready !== 1'b1 && n < 100) begin
			@(negedge i_ref_clk);
			n++;
		end
		chk({7'h00, ready}, 8'h01);
	endtask : wait_ready

	task automatic t_reset;
		chk({6'h00, data_oe_n, ready}, 8'h03);
		pgm.load(ACT_CMD, 1'b0, CMD_RD_FUSE_LOCK);
		pgm.rd(1'b0, 1'b0, v);
		chk({7'h00, data_oe_n}, 8'h00);
		chk(v, CELL_RST);
		@(negedge i_ref_clk);
		chk({7'h00, data_oe_n}, 8'h01);
		chk(rd_data, RD_NONE);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_flash;
		pgm.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
		pgm.load(ACT_ADDR, 1'b0, 8'h21);
		pgm.load(ACT_DATA, 1'b0, 8'hEF);
		pgm.load(ACT_DATA, 1'b1, 8'hBE);
		pgm.latch(1'b1);
		pgm.load(ACT_ADDR, 1'b0, 8'h22);
		pgm.load(ACT_DATA, 1'b0, 8'h34);
		pgm.load(ACT_DATA, 1'b1, 8'h12);
		pgm.latch(1'b1);
		pgm.load(ACT_ADDR, 1'b1, 8'h01);
		pgm.wr(1'b0, 1'b0);
		wait_ready();
		pgm.load(ACT_CMD, 1'b0, CMD_NOP);
		pgm.wr(1'b0, 1'b0);
		chk({7'h00, ready}, 8'h01);
		pgm.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
		pgm.load(ACT_ADDR, 1'b0, 8'h21);
		pgm.rd(1'b0, 1'b0, v);
		chk(v, 8'hEF);
		pgm.rd(1'b1, 1'b0, v);
		chk(v, 8'hBE);
		pgm.load(ACT_IDLE, 1'b0, 8'h22);
		pgm.rd(1'b1, 1'b0, v);
		chk(v, 8'hBE);
		pgm.load(ACT_ADDR, 1'b0, 8'h22);
		pgm.rd(1'b0, 1'b0, v);
		chk(v, 8'h34);
		$display("t_flash done");
	endtask : t_flash

	task automatic t_eeprom;
		pgm.load(ACT_CMD, 1'b0, CMD_WR_EEPROM);
		pgm.load(ACT_ADDR, 1'b1, 8'h01);
		pgm.load(ACT_ADDR, 1'b0, 8'h05);
		pgm.load(ACT_DATA, 1'b0, 8'hA5);
		pgm.latch(1'b0);
		pgm.load(ACT_ADDR, 1'b0, 8'h06);
		pgm.load(ACT_DATA, 1'b0, 8'h3C);
		pgm.latch(1'b0);
		pgm.wr(1'b0, 1'b0);
		wait_ready();
		pgm.load(ACT_CMD, 1'b0, CMD_RD_EEPROM);
		pgm.rd(1'b0, 1'b0, v);
		chk(v, 8'h3C);
		pgm.load(ACT_ADDR, 1'b0, 8'h05);
		pgm.rd(1'b0, 1'b0, v);
		chk(v, 8'hA5);
		$display("t_eeprom done");
	endtask : t_eeprom

	task automatic t_fuse_lock;
		pgm.load(ACT_CMD, 1'b0, CMD_WR_FUSE);
		pgm.load(ACT_DATA, 1'b0, 8'hE1);
		pgm.wr(1'b0, 1'b0);
		wait_ready();
		pgm.load(ACT_DATA, 1'b0, 8'h9F);
		pgm.wr(1'b1, 1'b0);
		wait_ready();
		pgm.load(ACT_CMD, 1'b0, CMD_WR_LOCK);
		pgm.load(ACT_DATA, 1'b0, 8'hFC);
		pgm.wr(1'b0, 1'b0);
		wait_ready();
		pgm.load(ACT_DATA, 1'b0, 8'hF3);
		pgm.wr(1'b0, 1'b0);
		wait_ready();
		pgm.load(ACT_CMD, 1'b0, CMD_RD_FUSE_LOCK);
		pgm.rd(1'b0, 1'b0, v);
		chk(v, 8'hE1);
		pgm.rd(1'b1, 1'b1, v);
		chk(v, 8'h9F);
		pgm.rd(1'b1, 1'b0, v);
		chk(v, 8'hF0);
		$display("t_fuse_lock done");
	endtask : t_fuse_lock

	task automatic t_ident;
		logic [7:0] ids [3];
		ids = '{8'h5A, 8'hC3, 8'h17};
		pgm.load(ACT_CMD, 1'b0, CMD_RD_SIG);
		for (int i = 0; i < 3; i++) begin
			pgm.load(ACT_ADDR, 1'b0, 8'(i));
			pgm.rd(1'b0, 1'b0, v);
			chk(v, ids[i]);
		end
		pgm.load(ACT_ADDR, 1'b0, 8'h03);
		pgm.rd(1'b1, 1'b0, v);
		chk(v, 8'h80);
		$display("t_ident done");
	endtask : t_ident

	initial begin
		bad_count = 0;
		n_tests = 0;
		cycles = 0;
		i_rst_n = 1'b0;
		repeat (20) @(negedge i_ref_clk);
		i_rst_n = 1'b1;
		repeat (2) @(negedge i_ref_clk);
		t_reset();
		t_flash();
		t_eeprom();
		t_fuse_lock();
		t_ident();
		test_done();
	end
endmodule : parallel_nvm_programming_port_bench
`default_nettype wire

// >>> shared/nvm_port_pkg.sv
package nvm_port_pkg;

	// Control pins sampled on the strobes
	typedef struct packed {
		logic action_sel_hi;
		logic action_sel_lo;
		logic byte_sel_one;
		logic byte_sel_two;
	} ctl_s;

	typedef enum logic [1:0] {
		ST_READY  = 2'b00,
		ST_COMMIT = 2'b01,
		ST_WAIT   = 2'b10
	} prog_state_e;

	typedef enum logic [1:0] {
		TGT_NONE   = 2'b00,
		TGT_FLASH  = 2'b01,
		TGT_EEPROM = 2'b10
	} target_e;

	// Action codes on the load strobe
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;

	// Command bytes
	localparam logic [7:0] CMD_NOP          = 8'h00;
	localparam logic [7:0] CMD_WR_FLASH     = 8'h10;
	localparam logic [7:0] CMD_WR_EEPROM    = 8'h11;
	localparam logic [7:0] CMD_WR_FUSE      = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK      = 8'h20;
	localparam logic [7:0] CMD_RD_SIG       = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE_LOCK = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH     = 8'h02;
	localparam logic [7:0] CMD_RD_EEPROM    = 8'h03;

	// Memory geometry
	localparam int FLASH_ADDR_W  = 12;
	localparam int FLASH_WORD_W  = 5;
	localparam int FLASH_WORDS   = 4096;
	localparam int PAGE_WORDS    = 32;
	localparam int EE_ADDR_W     = 9;
	localparam int EE_WORD_W     = 2;
	localparam int EE_BYTES      = 512;
	localparam int EE_PAGE_BYTES = 4;

	// Reset values of the loaded bytes and fuse cells
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] CELL_RST = 8'hFF;
	localparam logic [7:0] RD_NONE  = 8'h00;

	// Self-timed programming, least time rounded up
	localparam int CLK_PERIOD_NS = 100;
	localparam int PROG_TIME_NS  = 3700000;
	localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : nvm_port_pkg

// >>> src/nvm_prog_port.sv
// Behaviour
// - Action 10, select 0 loads command
// - Command 10h writes Flash pages
// - Action 00 loads low/high address byte
// - Action 01 loads low/high data byte
// - Page latch copies data word into buffer
// - Low bits pick word, high bits page
// - Write pulse programs Flash page, busy low
// - No-operation command clears write arming
// - Command 11h writes EEPROM pages bytewise
// - Read Flash low/high byte on bus
// - Read EEPROM byte on bus
// - Command 40h writes low/high fuses
// - Lock bits only ever get programmed
// - Read fuses and lock bits by selects
// - Read identification byte by low address
// - Select one reads calibration byte
// - Drive bus only while enable low
// - Ready low while programming, else high
// - Command and address kept across operations
`timescale 1ns/100ps
`default_nettype none
module nvm_prog_port
	import nvm_port_pkg::*;
#(
	parameter int unsigned PROG_CYCLES_P = PROG_CYCLES,
	parameter logic [7:0]  FUSE_LO_INIT  = CELL_RST,
	parameter logic [7:0]  FUSE_HI_INIT  = CELL_RST,
	// Identification and calibration values are arbitrary
	parameter logic [7:0]  ID_BYTE0      = 8'h5A,
	parameter logic [7:0]  ID_BYTE1      = 8'hC3,
	parameter logic [7:0]  ID_BYTE2      = 8'h17,
	parameter logic [7:0]  CALIB_BYTE    = 8'h80
) (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	// Strobes from the programmer
	input  wire logic       i_load_strobe,
	input  wire logic       i_page_buffer_latch,
	input  wire logic       i_wr_n,
	input  wire logic       i_oe_n,
	// Action and byte selects
	input  wire ctl_s       i_ctl,
	// Data bus
	input  wire logic [7:0] i_data,
	output logic      [7:0] o_data,
	output logic            o_data_oe_n,
	// Status
	output logic            o_ready_busy_out
);

	logic [7:0]              cmd_reg;
	logic [7:0]              addr_lo_reg;
	logic [7:0]              addr_hi_reg;
	logic [7:0]              data_lo_reg;
	logic [7:0]              data_hi_reg;
	logic                    write_arm_reg;
	logic [7:0]              fuse_lo_reg;
	logic [7:0]              fuse_hi_reg;
	logic [7:0]              lock_reg;
	logic                    strobe_d_reg;
	logic                    latch_d_reg;
	logic                    wr_n_d_reg;
	prog_state_e             state_reg;
	target_e                 target_reg;
	logic [FLASH_ADDR_W-1:0] wr_addr_reg;
	logic [FLASH_WORD_W-1:0] commit_cnt_reg;
	logic [15:0]             flash_mem [0:FLASH_WORDS-1];
	logic [7:0]              eeprom_mem [0:EE_BYTES-1];
	logic [15:0]             flash_buf [0:PAGE_WORDS-1];
	logic [7:0]              eeprom_buf [0:EE_PAGE_BYTES-1];
	logic                    strobe_rise;
	logic                    latch_rise;
	logic                    wr_fall;
	logic                    ready;
	logic                    start_prog;
	logic                    timer_busy;
	logic [1:0]              action;
	logic [FLASH_ADDR_W-1:0] flash_addr;
	logic [EE_ADDR_W-1:0]    ee_addr;
	logic [15:0]             flash_rd_word;
	logic [7:0]              eeprom_rd_byte;
	logic [7:0]              rd_byte;
	logic [FLASH_WORD_W-1:0] commit_last;

	assign action         = {i_ctl.action_sel_hi, i_ctl.action_sel_lo};
	assign strobe_rise    = i_load_strobe && !strobe_d_reg;
	assign latch_rise     = i_page_buffer_latch && !latch_d_reg;
	assign wr_fall        = !i_wr_n && wr_n_d_reg;
	assign ready          = (state_reg == ST_READY);
	assign flash_addr     = {addr_hi_reg[FLASH_ADDR_W-9:0], addr_lo_reg};
	assign ee_addr        = {addr_hi_reg[EE_ADDR_W-9:0], addr_lo_reg};
	assign flash_rd_word  = flash_mem[flash_addr];
	assign eeprom_rd_byte = eeprom_mem[ee_addr];
	assign commit_last    = (target_reg == TGT_FLASH) ? FLASH_WORD_W'(PAGE_WORDS - 1)
	                                                  : FLASH_WORD_W'(EE_PAGE_BYTES - 1);

	// Write pulse start, fuses choose their byte with the selects
	assign start_prog = wr_fall && ready && write_arm_reg &&
		((cmd_reg == CMD_WR_FUSE) ? !i_ctl.byte_sel_two : !i_ctl.byte_sel_one);

	// Edge detection of the strobes
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			strobe_d_reg <= 1'b0;
			latch_d_reg  <= 1'b0;
			wr_n_d_reg   <= 1'b1;
		end else begin
			strobe_d_reg <= i_load_strobe;
			latch_d_reg  <= i_page_buffer_latch;
			wr_n_d_reg   <= i_wr_n;
		end
	end

	// Command, address and data capture, held until reloaded
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_reg       <= CMD_NOP;
			addr_lo_reg   <= BYTE_RST;
			addr_hi_reg   <= BYTE_RST;
			data_lo_reg   <= BYTE_RST;
			data_hi_reg   <= BYTE_RST;
			write_arm_reg <= 1'b0;
		end else if (strobe_rise && ready) begin
			if (action == ACT_CMD) begin
				if (!i_ctl.byte_sel_one) begin
					cmd_reg       <= i_data;
					write_arm_reg <= (i_data == CMD_WR_FLASH) || (i_data == CMD_WR_EEPROM) ||
						(i_data == CMD_WR_FUSE) || (i_data == CMD_WR_LOCK);
				end
			end else if (action == ACT_ADDR) begin
				if (i_ctl.byte_sel_one) begin
					addr_hi_reg <= i_data;
				end else begin
					addr_lo_reg <= i_data;
				end
			end else if (action == ACT_DATA) begin
				if (i_ctl.byte_sel_one) begin
					data_hi_reg <= i_data;
				end else begin
					data_lo_reg <= i_data;
				end
			end
			// ACT_IDLE leaves every byte alone
		end
	end

	// Page buffers filled by the page latch pulse
	always_ff @(posedge i_ref_clk) begin
		if (latch_rise && ready) begin
			if (cmd_reg == CMD_WR_FLASH && i_ctl.byte_sel_one) begin
				flash_buf[addr_lo_reg[FLASH_WORD_W-1:0]] <= {data_hi_reg, data_lo_reg};
			end else if (cmd_reg == CMD_WR_EEPROM) begin
				eeprom_buf[addr_lo_reg[EE_WORD_W-1:0]] <= data_lo_reg;
			end
		end
	end

	// Programming sequence: commit buffer, then wait out the timer
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg        <= ST_READY;
			target_reg       <= TGT_NONE;
			wr_addr_reg      <= '0;
			commit_cnt_reg   <= '0;
			o_ready_busy_out <= 1'b1;
		end else begin
			case (state_reg)
				ST_READY: begin
					if (start_prog) begin
						o_ready_busy_out <= 1'b0;
						commit_cnt_reg   <= '0;
						wr_addr_reg      <= flash_addr;
						if (cmd_reg == CMD_WR_FLASH) begin
							target_reg <= TGT_FLASH;
							state_reg  <= ST_COMMIT;
						end else if (cmd_reg == CMD_WR_EEPROM) begin
							target_reg <= TGT_EEPROM;
							state_reg  <= ST_COMMIT;
						end else begin
							target_reg <= TGT_NONE;
							state_reg  <= ST_WAIT;
						end
					end
				end
				ST_COMMIT: begin
					commit_cnt_reg <= commit_cnt_reg + 1'b1;
					if (commit_cnt_reg == commit_last) begin
						state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (!timer_busy) begin
						state_reg        <= ST_READY;
						o_ready_busy_out <= 1'b1;
					end
				end
				default: begin
					state_reg <= ST_READY;
				end
			endcase
		end
	end

	// Array writes, one word per cycle; page from upper address bits
	always_ff @(posedge i_ref_clk) begin
		if (state_reg == ST_COMMIT && target_reg == TGT_FLASH) begin
			flash_mem[{wr_addr_reg[FLASH_ADDR_W-1:FLASH_WORD_W], commit_cnt_reg}] <=
				flash_buf[commit_cnt_reg];
		end
		if (state_reg == ST_COMMIT && target_reg == TGT_EEPROM) begin
			eeprom_mem[{wr_addr_reg[EE_ADDR_W-1:EE_WORD_W], commit_cnt_reg[EE_WORD_W-1:0]}] <=
				eeprom_buf[commit_cnt_reg[EE_WORD_W-1:0]];
		end
	end

	// Fuse and lock cells
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fuse_lo_reg <= FUSE_LO_INIT;
			fuse_hi_reg <= FUSE_HI_INIT;
			lock_reg    <= CELL_RST;
		end else if (start_prog) begin
			if (cmd_reg == CMD_WR_FUSE) begin
				if (i_ctl.byte_sel_one) begin
					fuse_hi_reg <= data_lo_reg;
				end else begin
					fuse_lo_reg <= data_lo_reg;
				end
			end else if (cmd_reg == CMD_WR_LOCK) begin
				lock_reg <= lock_reg & data_lo_reg;
			end
		end
	end

	prog_timer #(
		.CYCLES (PROG_CYCLES_P)
	) u_prog_timer (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_start   (start_prog),
		.o_busy    (timer_busy)
	);

	// Read data selection
	always_comb begin
		rd_byte = RD_NONE;
		if (cmd_reg == CMD_RD_FLASH) begin
			rd_byte = i_ctl.byte_sel_one ? flash_rd_word[15:8] : flash_rd_word[7:0];
		end else if (cmd_reg == CMD_RD_EEPROM) begin
			if (!i_ctl.byte_sel_one) begin
				rd_byte = eeprom_rd_byte;
			end
		end else if (cmd_reg == CMD_RD_FUSE_LOCK) begin
			case ({i_ctl.byte_sel_two, i_ctl.byte_sel_one})
				2'b00:   rd_byte = fuse_lo_reg;
				2'b11:   rd_byte = fuse_hi_reg;
				2'b01:   rd_byte = lock_reg;
				default: rd_byte = RD_NONE;
			endcase
		end else if (cmd_reg == CMD_RD_SIG) begin
			if (i_ctl.byte_sel_one) begin
				rd_byte = CALIB_BYTE;
			end else if (addr_lo_reg == 8'h00) begin
				rd_byte = ID_BYTE0;
			end else if (addr_lo_reg == 8'h01) begin
				rd_byte = ID_BYTE1;
			end else if (addr_lo_reg == 8'h02) begin
				rd_byte = ID_BYTE2;
			end
		end
	end

	// Bus driver, enable low while driving
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_data      <= RD_NONE;
			o_data_oe_n <= 1'b1;
		end else begin
			o_data_oe_n <= i_oe_n;
			o_data      <= i_oe_n ? RD_NONE : rd_byte;
		end
	end

	// Checks
	cmd_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		strobe_rise && ready && action == ACT_CMD && !i_ctl.byte_sel_one
		|=> cmd_reg == $past(i_data)) else $error("command not captured");

	addr_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		strobe_rise && ready && action == ACT_ADDR
		|=> ($past(i_ctl.byte_sel_one) ? addr_hi_reg : addr_lo_reg) == $past(i_data))
		else $error("address not captured");

	data_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		strobe_rise && ready && action == ACT_DATA && i_ctl.byte_sel_one
		|=> data_hi_reg == $past(i_data)) else $error("data high not captured");

	idle_action_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		strobe_rise && action == ACT_IDLE
		|=> $stable(cmd_reg) && $stable(addr_lo_reg) && $stable(data_lo_reg)) else $error("idle changed state");

	busy_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		start_prog |=> !o_ready_busy_out [*8]) else $error("busy not shown after write");

	nop_disarm_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		strobe_rise && ready && action == ACT_CMD && !i_ctl.byte_sel_one && i_data == CMD_NOP
		|=> !write_arm_reg ##1 !start_prog) else $error("nop left write armed");

	lock_only_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		1'b1 |=> (lock_reg & ~$past(lock_reg)) == 8'h00) else $error("lock bit erased");

	fuse_lo_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		start_prog && cmd_reg == CMD_WR_FUSE && !i_ctl.byte_sel_one
		|=> fuse_lo_reg == $past(data_lo_reg)) else $error("low fuse not written");

	oe_follow_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		1'b1 |=> o_data_oe_n == $past(i_oe_n) && (o_data_oe_n || o_data == $past(rd_byte)))
		else $error("bus drive wrong");

	flash_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!i_oe_n && cmd_reg == CMD_RD_FLASH && !i_ctl.byte_sel_one
		|=> o_data == $past(flash_rd_word[7:0])) else $error("flash low byte wrong");

	ready_back_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		state_reg == ST_WAIT && !timer_busy |=> o_ready_busy_out && ready) else $error("ready not restored");

	flash_prog_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		start_prog && cmd_reg == CMD_WR_FLASH ##1 state_reg == ST_COMMIT);
	eeprom_prog_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		start_prog && cmd_reg == CMD_WR_EEPROM);
	lock_prog_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		start_prog && cmd_reg == CMD_WR_LOCK);
	sig_read_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!i_oe_n && cmd_reg == CMD_RD_SIG);

endmodule : nvm_prog_port
`default_nettype wire

// >>> src/prog_timer.sv
`timescale 1ns/100ps
`default_nettype none
module prog_timer
	import nvm_port_pkg::*;
#(
	parameter int unsigned CYCLES = PROG_CYCLES
) (
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	// Control
	input  wire logic i_start,
	output logic      o_busy
);

	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] count_reg;

	// Down counter for the programming time
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_reg <= '0;
			o_busy    <= 1'b0;
		end else if (i_start) begin
			count_reg <= W'(CYCLES - 1);
			o_busy    <= 1'b1;
		end else if (o_busy) begin
			if (count_reg == '0) begin
				o_busy <= 1'b0;
			end else begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	timer_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$rose(o_busy) |-> o_busy[*8]) else $error("timer busy too short");

endmodule : prog_timer
`default_nettype wire
